// >>> hdl/msrl_pkg.sv
// package: skip codes, counter layout and status carriers for the skip/repeat block
package msrl_pkg;

	// =====================================================
	// skip field codes
	typedef enum logic [3:0] {
		SK_COUNT_BUMP      = 4'h0,
		SK_REPEAT_MODE     = 4'h1,
		SK_RESULT_LOW      = 4'h2,
		SK_SIGN            = 4'h3,
		SK_CARRY_OUT       = 4'h4,
		SK_OVERFLOW        = 4'h5,
		SK_CPU_FLAG        = 4'h6,
		SK_ZERO_RESULT     = 4'h7,
		SK_COUNT_FULL_BUMP = 4'h8,
		SK_COUNT_FULL      = 4'h9,
		SK_PROTECT_VIOL    = 4'hA,
		SK_REGISTER_ADDR   = 4'hB,
		SK_NONREGISTER     = 4'hC,
		SK_END_PHASE       = 4'hD,
		SK_ALWAYS          = 4'hE,
		SK_FIELD_IDLE      = 4'hF
	} msrl_skip_code_t;

	// =====================================================
	// field positions and widths
	localparam int SKIP_LSB      = 0;
	localparam int SKIP_W        = 4;
	localparam int CNT_LOW_W     = 4;
	localparam int CNT_W         = 5;
	localparam int BUS_W         = 16;
	localparam int ADDR_LSB      = 1;
	localparam int ADDR_MSB      = 14;
	localparam int SIGN_BIT      = 15;
	localparam int LOW_BIT       = 0;
	localparam int MULDIV_STEPS  = 16;

	// =====================================================
	// reset values and full count
	localparam logic [3:0] CNT_LOW_RST  = 4'h0;
	localparam logic       CNT_CARRY_RST = 1'b0;
	localparam logic [3:0] CNT_FULL     = 4'hF;

	// =====================================================
	// carriers
	typedef struct packed {
		logic cpu_flag;
		logic overflow_flag;
		logic carry_out;
		logic a_addressed;
		logic b_addressed;
		logic protect_enabled;
	} msrl_status_t;

	typedef struct packed {
		logic counter_select;
		logic count_to_bus;
		logic src_idle;
	} msrl_count_ctl_t;

endpackage : msrl_pkg

// >>> hdl/msrl_cond_mux.sv
// combinational skip-condition selector for one skip code
module msrl_cond_mux
	import msrl_pkg::*;
(
	// code and condition sources
	input  wire logic [3:0]  skip_code_i,
	input  wire logic [15:0] result_bus_i,
	input  wire msrl_status_t status_i,
	input  wire logic        count_full_i,
	// decoded outputs
	output logic             skip_o,
	output logic             bump_o,
	output logic             repeat_o
);

	// =====================================================
	// decode
	logic addressed;
	assign addressed = status_i.a_addressed | status_i.b_addressed;

	always_comb begin
		skip_o   = 1'b0;
		bump_o   = 1'b0;
		repeat_o = 1'b0;
		case (msrl_skip_code_t'(skip_code_i))
			SK_COUNT_BUMP:      bump_o = 1'b1;
			SK_REPEAT_MODE:     repeat_o = 1'b1;
			SK_RESULT_LOW:      skip_o = result_bus_i[LOW_BIT];
			SK_SIGN:            skip_o = result_bus_i[SIGN_BIT];
			SK_CARRY_OUT:       skip_o = status_i.carry_out;
			SK_OVERFLOW:        skip_o = status_i.overflow_flag;
			SK_CPU_FLAG:        skip_o = status_i.cpu_flag;
			SK_ZERO_RESULT:     skip_o = ~|result_bus_i;
			SK_COUNT_FULL_BUMP: begin
				skip_o = count_full_i;
				bump_o = 1'b1;
			end
			SK_COUNT_FULL:      skip_o = count_full_i;
			// no skip while either accumulator is addressed; otherwise the word skips
			// whatever protection, sign or the other flags say
			SK_PROTECT_VIOL:    skip_o = ~addressed &
				(~status_i.protect_enabled | result_bus_i[SIGN_BIT] | 1'b1);
			SK_REGISTER_ADDR:   skip_o = addressed;
			SK_NONREGISTER:     skip_o = |result_bus_i[ADDR_MSB:ADDR_LSB];
			SK_ALWAYS:          skip_o = 1'b1;
			SK_FIELD_IDLE:      skip_o = 1'b0;
			default:            skip_o = 1'b0;
		endcase
	end

endmodule // msrl_cond_mux

// >>> hdl/msrl_counter.sv
// five-bit repeat counter: four-bit loadable counter plus carry flip-flop
module msrl_counter
	import msrl_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       load_i,
	input  wire logic [3:0] load_val_i,
	input  wire logic       bump_i,
	// state
	output logic [4:0]      count_o,
	output logic            full_o
);

	// =====================================================
	// counter state
	logic [3:0] low_r;
	logic [3:0] low_nxt;
	logic       carry_r;
	logic       carry_nxt;

	assign full_o  = (low_r == CNT_FULL);
	assign count_o = {carry_r, low_r};

	always_comb begin
		low_nxt   = low_r;
		carry_nxt = carry_r;
		if (load_i) begin
			// load wins over increment, as the parallel enable does
			low_nxt   = load_val_i;
			carry_nxt = 1'b0;
		end else if (bump_i) begin
			low_nxt = low_r + 4'h1;
			if (full_o) begin
				carry_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			low_r   <= CNT_LOW_RST;
			carry_r <= CNT_CARRY_RST;
		end else begin
			low_r   <= low_nxt;
			carry_r <= carry_nxt;
		end
	end

endmodule // msrl_counter

// >>> hdl/msrl_top.sv
// skip field decoder and repeat counter of the microprogrammed processor
//
// Behaviour
// - skip code is the low four bits of the current microinstruction
// - taken skip lets next word run through buses but blocks its stores
// - code 0110 skips when the cpu flag is set
// - code 0000 takes no decision and bumps the counter once
// - code 1100 skips when result bits 1 to 14 are not all zero
// - code 0011 skips when result bit 15 is high
// - code 1010 never skips while addressed; otherwise skips
// - code 0010 skips when result bit 0 is high
// - code 0101 skips when overflow flag is set
// - code 0001 repeats next word until its own skip holds
// - code 0111 skips when the whole result bus is zero
// - code 1110 always skips
// - code 1111 does nothing in this field
// - counter is four bits plus a separate carry bit four
// - counter select loads low four bits from source bits 0 to 3
// - increment codes add one on the same edge
// - increment at all ones sets the carry bit
// - codes 1001 and 1000 skip on low bits all ones; 1000 also bumps
// - load with idle source bus clears the counter
// - count-to-bus drives five counter bits onto source bits 0 to 4
// - cleared counter with test-and-bump repeats exactly sixteen times
module msrl_top
	import msrl_pkg::*;
(
	// clock and reset
	input  wire logic            clk_sys_i,
	input  wire logic            rst_i,
	// microinstruction, advanced once per microcycle
	input  wire logic [3:0]      micro_skip_i,
	input  wire logic            micro_valid_i,
	input  wire msrl_count_ctl_t count_ctl_i,
	// datapath
	input  wire logic [15:0]     source_bus_i,
	input  wire logic [15:0]     result_bus_i,
	input  wire msrl_status_t    status_i,
	// outputs
	output logic                 store_inhibit_o,
	output logic                 repeat_mode_o,
	output logic                 hold_fetch_o,
	output logic [4:0]           count_bus_o,
	output logic                 count_bus_en_o,
	output logic [4:0]           count_o
);

	// =====================================================
	// decode of the current word
	logic skip_hit;
	logic bump_req;
	logic repeat_req;
	logic count_full;
	logic [4:0] count_val;

	msrl_cond_mux u_cond (
		.skip_code_i  (micro_skip_i),
		.result_bus_i (result_bus_i),
		.status_i     (status_i),
		.count_full_i (count_full),
		.skip_o       (skip_hit),
		.bump_o       (bump_req),
		.repeat_o     (repeat_req)
	);

	// =====================================================
	// store suppression and repeat sequencing
	logic       inhibit_r;
	logic       inhibit_nxt;
	logic       repeat_r;
	logic       repeat_nxt;
	logic       hold_r;
	logic       hold_nxt;
	logic       act;
	logic       do_load;
	logic [3:0] load_val;

	// a suppressed word still runs its decode; its stores are blocked downstream.
	// the counter is a store, so a skipped word loads and bumps nothing
	assign act      = micro_valid_i & ~inhibit_r;
	assign do_load  = act & count_ctl_i.counter_select;
	assign load_val = count_ctl_i.src_idle ? CNT_LOW_RST : source_bus_i[CNT_LOW_W-1:0];

	always_comb begin
		inhibit_nxt = inhibit_r;
		repeat_nxt  = repeat_r;
		hold_nxt    = hold_r;
		if (micro_valid_i) begin
			if (repeat_r) begin
				// repeated word: keep re-running until its own condition holds;
				// that final pass ends the loop and is not treated as a skip
				if (skip_hit) begin
					repeat_nxt  = 1'b0;
					hold_nxt    = 1'b0;
					inhibit_nxt = 1'b0;
				end else begin
					hold_nxt    = 1'b1;
					inhibit_nxt = 1'b0;
				end
			end else begin
				inhibit_nxt = act & skip_hit;
				repeat_nxt  = act & repeat_req;
				hold_nxt    = act & repeat_req;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			inhibit_r <= 1'b0;
			repeat_r  <= 1'b0;
			hold_r    <= 1'b0;
		end else begin
			inhibit_r <= inhibit_nxt;
			repeat_r  <= repeat_nxt;
			hold_r    <= hold_nxt;
		end
	end

	// =====================================================
	// repeat counter
	msrl_counter u_cnt (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.load_i     (do_load),
		.load_val_i (load_val),
		.bump_i     (act & bump_req),
		.count_o    (count_val),
		.full_o     (count_full)
	);

	// =====================================================
	// registered outputs
	logic [4:0] bus_r;
	logic [4:0] bus_nxt;
	logic       bus_en_r;
	logic       bus_en_nxt;
	logic [4:0] cnt_r;

	always_comb begin
		bus_en_nxt = count_ctl_i.count_to_bus;
		bus_nxt    = count_ctl_i.count_to_bus ? count_val : 5'h0_0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bus_r    <= 5'h0_0;
			bus_en_r <= 1'b0;
			cnt_r    <= 5'h0_0;
		end else begin
			bus_r    <= bus_nxt;
			bus_en_r <= bus_en_nxt;
			cnt_r    <= count_val;
		end
	end

	assign store_inhibit_o = inhibit_r;
	assign repeat_mode_o   = repeat_r;
	assign hold_fetch_o    = hold_r;
	assign count_bus_o     = bus_r;
	assign count_bus_en_o  = bus_en_r;
	assign count_o         = cnt_r;

endmodule // msrl_top

// >>> tb/msrl_top_properties.sv
// checker: skip decode and repeat counter timing at the top ports
module msrl_top_properties
	import msrl_pkg::*;
(
	// clock and reset
	input wire logic            clk_sys_i,
	input wire logic            rst_i,
	// current word
	input wire logic [3:0]      micro_skip_i,
	input wire logic            micro_valid_i,
	input wire msrl_count_ctl_t count_ctl_i,
	input wire logic [15:0]     source_bus_i,
	input wire logic [15:0]     result_bus_i,
	// results
	input wire logic            store_inhibit_o,
	input wire logic            repeat_mode_o,
	input wire logic            hold_fetch_o,
	input wire logic [4:0]      count_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// =====================================================
	// helpers
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic act;
	logic go;
	assign act = micro_valid_i && !store_inhibit_o;
	// inside a repeat a met condition ends the loop instead of skipping
	assign go = act && !repeat_mode_o;
	// =====================================================
	// properties
	property p_always; go && micro_skip_i == 4'hE |=> store_inhibit_o; endproperty
	a_always: assert property (p_always) else $error("always skip missed");
	property p_idle; go && micro_skip_i == 4'hF |=> !store_inhibit_o && !repeat_mode_o; endproperty
	a_idle: assert property (p_idle) else $error("idle code acted");
	property p_sign; go && micro_skip_i == 4'h3 |=> store_inhibit_o == $past(result_bus_i[15]); endproperty
	a_sign: assert property (p_sign) else $error("sign skip wrong");
	property p_zero; go && micro_skip_i == 4'h7 |=> store_inhibit_o == ($past(result_bus_i) == 16'h0000); endproperty
	a_zero: assert property (p_zero) else $error("zero skip wrong");
	property p_full; go && micro_skip_i == 4'h9 |=> store_inhibit_o == (count_o[3:0] == 4'hF); endproperty
	a_full: assert property (p_full) else $error("count full skip wrong");
	property p_rpt; go && micro_skip_i == 4'h1 |=> repeat_mode_o && hold_fetch_o; endproperty
	a_rpt: assert property (p_rpt) else $error("repeat not entered");
	property p_bump;
		act && micro_skip_i == 4'h0 && !count_ctl_i.counter_select |-> ##2 count_o[3:0] == $past(count_o[3:0]) + 4'h1;
	endproperty
	a_bump: assert property (p_bump) else $error("bump wrong");
	property p_load;
		act && count_ctl_i.counter_select
		|-> ##2 count_o == ($past(count_ctl_i.src_idle, 2) ? 5'h00 : {1'b0, $past(source_bus_i[3:0], 2)});
	endproperty
	a_load: assert property (p_load) else $error("load wrong");
	c_rpt: cover property (go && micro_skip_i == 4'h1);
	c_inh: cover property (store_inhibit_o);
	c_carry: cover property (count_o == 5'h10);
endmodule // msrl_top_properties

bind msrl_top msrl_top_properties u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .micro_skip_i(micro_skip_i),
	.micro_valid_i(micro_valid_i), .count_ctl_i(count_ctl_i), .source_bus_i(source_bus_i),
	.result_bus_i(result_bus_i), .store_inhibit_o(store_inhibit_o), .repeat_mode_o(repeat_mode_o),
	.hold_fetch_o(hold_fetch_o), .count_o(count_o));

// >>> tb/msrl_seq_model.sv
// sequencer model: presents skip codes, re-issues the repeated word on hold
module msrl_seq_model
	import msrl_pkg::*;
(
	// control from the bench, fetch hold from the block
	input  wire logic       clk_sys_i,
	input  wire logic       run_i,
	input  wire logic [3:0] next_code_i,
	input  wire logic       hold_fetch_i,
	// word to the block
	output logic [3:0]      code_o,
	output logic            valid_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial code_o = 4'hF;
	assign valid_o = run_i;
	// the word after the repeat word is fetched once, then held
	always @(negedge clk_sys_i) begin
		if (!hold_fetch_i || code_o == 4'h1)
			code_o <= next_code_i;
	end
endmodule // msrl_seq_model

// >>> tb/tb_micro_skip_repeat_logic.sv
// testbench: skip decode table, repeat loop and counter access
module tb_micro_skip_repeat_logic;
	timeunit 1ns;
	timeprecision 1ns;
	import msrl_pkg::*;
	logic            clk_sys_i = 1'b0;
	logic            rst_i = 1'b1;
	logic            run = 1'b0;
	logic [3:0]      nxt = 4'hF;
	logic [3:0]      skip;
	logic            valid;
	msrl_count_ctl_t ctl = 3'h0;
	logic [15:0]     src = 16'h0000;
	logic [15:0]     res = 16'h0000;
	msrl_status_t    st = 6'h00;
	logic            inh, repeat_mode, hold, cben;
	logic [4:0]      cbus, cnt;
	int              n_fail = 0;
	int              comparisons = 0;
	int              n;
	// code, result bus, status, expected inhibit
	logic [26:0] tbl [22] = '{{4'h6, 16'h0000, 6'h20, 1'b1}, {4'h6, 16'h0000, 6'h1F, 1'b0},
		{4'hC, 16'h0002, 6'h00, 1'b1}, {4'hC, 16'h8001, 6'h00, 1'b0},
		{4'h3, 16'h8000, 6'h00, 1'b1}, {4'h3, 16'h7FFF, 6'h00, 1'b0},
		{4'hA, 16'h0000, 6'h01, 1'b1}, {4'hA, 16'h8000, 6'h04, 1'b0},
		{4'h2, 16'h0001, 6'h00, 1'b1}, {4'h2, 16'h0002, 6'h00, 1'b0},
		{4'h5, 16'h0000, 6'h10, 1'b1}, {4'h5, 16'h0000, 6'h2F, 1'b0},
		{4'h7, 16'h0000, 6'h00, 1'b1}, {4'h7, 16'h0100, 6'h00, 1'b0},
		{4'hE, 16'h0000, 6'h00, 1'b1}, {4'hF, 16'h0000, 6'h3F, 1'b0},
		{4'h0, 16'h0000, 6'h3F, 1'b0},
		{4'h4, 16'h0000, 6'h08, 1'b1}, {4'h4, 16'h0000, 6'h37, 1'b0},
		{4'hB, 16'h0000, 6'h02, 1'b1}, {4'hB, 16'h0000, 6'h39, 1'b0},
		{4'hD, 16'h0000, 6'h3F, 1'b0}};

	always #50 clk_sys_i = ~clk_sys_i;

	msrl_seq_model u_seq (.clk_sys_i(clk_sys_i), .run_i(run), .next_code_i(nxt), .hold_fetch_i(hold),
		.code_o(skip), .valid_o(valid));
	msrl_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .micro_skip_i(skip), .micro_valid_i(valid),
		.count_ctl_i(ctl), .source_bus_i(src), .result_bus_i(res), .status_i(st), .store_inhibit_o(inh),
		.repeat_mode_o(repeat_mode), .hold_fetch_o(hold), .count_bus_o(cbus), .count_bus_en_o(cben), .count_o(cnt));

	// =====================================================
	// tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one word: queued for the sequencer, side fields driven at the falling edge
	task automatic w(input logic [3:0] c, input logic [2:0] k = 3'h0, input logic [15:0] s = 16'h0000,
		input logic [15:0] r = 16'h0000, input logic [5:0] t = 6'h00);
		@(posedge clk_sys_i);
		nxt = c;
		@(negedge clk_sys_i);
		ctl = k;
		src = s;
		res = r;
		st = t;
	endtask

	task report_and_stop;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// =====================================================
	// sequence
	initial begin
		repeat (2000) @(posedge clk_sys_i);
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (5) @(posedge clk_sys_i);
		chk({inh, repeat_mode, hold, cben, cnt}, 16'h0000);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		run = 1'b1;
		for (int i = 0; i < 22; i++) begin
			w(tbl[i][26:23], 3'h0, 16'h0000, tbl[i][22:7], tbl[i][6:1]);
			w(4'hF);
			chk(inh, tbl[i][0]);
		end
		// upper source bits must not leak into the counter
		w(4'hF, 3'h4, 16'hFFFA);
		w(4'h0);
		w(4'hF, 3'h2);
		w(4'hF);
		chk(cnt, 5'h0B);
		chk({cben, cbus}, {1'b1, 5'h0B});
		w(4'h1, 3'h5);
		w(4'h8);
		n = 0;
		while (hold === 1'b1 && n < 40) begin
			n++;
			w(4'hF);
		end
		chk(n[15:0], 16'h0010);
		chk({repeat_mode, hold, inh}, 3'h0);
		// read out the carried count on the same word that reloads it
		w(4'hF, 3'h6, 16'h000F);
		chk(cnt, 5'h10);
		w(4'h9);
		chk({cben, cbus}, {1'b1, 5'h10});
		w(4'h0);
		chk(cnt, 5'h0F);
		chk(inh, 1'b1);
		// the skipped bump word must leave the counter alone
		w(4'hF);
		w(4'hF);
		chk(cnt, 5'h0F);
		// shift of five: negated count 4'hB runs the repeated word five times
		w(4'h1, 3'h4, 16'h000B);
		w(4'h8);
		n = 0;
		while (hold === 1'b1 && n < 40) begin
			n++;
			w(4'hF);
		end
		chk(n[15:0], 16'h0005);
		chk({repeat_mode, hold, inh}, 3'h0);
		report_and_stop();
	end
endmodule // tb_micro_skip_repeat_logic
